/* common/cmms_pkg.sv */
package cmms_pkg;
	// Machine timing
	localparam int          STATES_PER_MCYCLE = 3;
	localparam int          MCYCLE_MIN        = 1;
	localparam int          MCYCLE_MAX        = 5;
	localparam logic [1:0]  STATE_LAST        = 2'h2;
	localparam logic [2:0]  MCYCLE_LAST       = 3'h4;
	// Program memory map
	localparam int          PC_W              = 11;
	localparam logic [10:0] PC_RESET          = 11'h000;
	localparam logic [10:0] CZP_LO            = 11'h010;
	localparam logic [10:0] CZP_HI            = 11'h01F;
	localparam logic [10:0] VEC_LO            = 11'h020;
	localparam logic [10:0] VEC_HI            = 11'h03D;
	localparam logic [10:0] TEST_LO           = 11'h7E0;
	localparam logic [10:0] TEST_HI           = 11'h7FF;
	// Stack pointer
	localparam logic [7:0]  SP_RESET          = 8'hFF;
	localparam logic [5:0]  SP_CNT_RESET      = 6'h3F;
	// Data memory map
	localparam logic [2:0]  BANK0             = 3'h0;
	localparam logic [2:0]  BANK7             = 3'h7;
	localparam logic [7:0]  COMMON_HI         = 8'h7F;
	localparam logic [10:0] RAM_LO            = 11'h780;
	localparam logic [10:0] SFR_TOP           = 11'h07F;
	// Register bus offsets (byte addresses)
	localparam logic [5:0]  OFF_SP            = 6'h00;
	localparam logic [5:0]  OFF_BANK          = 6'h04;
	localparam logic [5:0]  OFF_PTR           = 6'h08;
	localparam logic [5:0]  OFF_CTRL          = 6'h0C;
	localparam logic [5:0]  OFF_PC            = 6'h10;
	localparam logic [5:0]  OFF_DADDR         = 6'h14;
	localparam logic [5:0]  OFF_STATUS        = 6'h18;
	localparam logic [5:0]  OFF_ACC           = 6'h1C;
	// Control register fields
	localparam int          CTRL_RUN          = 0;
	localparam int          CTRL_PUSH         = 1;
	localparam int          CTRL_POP          = 2;
	localparam int          CTRL_IRQ          = 3;
	localparam int          CTRL_ADD          = 4;
	localparam int          CTRL_SUB          = 5;
	localparam int          CTRL_CZP          = 6;
	localparam int          CTRL_JUMP         = 7;
	localparam int          CTRL_MODE_LSB     = 8;
	localparam int          CTRL_LEN_LSB      = 12;
	localparam int          CTRL_VEC_LSB      = 16;
	// Access modes
	typedef enum logic [1:0] {
		MODE_PRIMARY   = 2'h0,
		MODE_SECONDARY = 2'h1,
		MODE_DIRECT    = 2'h2,
		MODE_STACK     = 2'h3
	} cmms_mode_t;
	// Interrupt entry sequence, one-hot
	typedef enum logic [3:0] {
		IRQ_IDLE = 4'h1,
		IRQ_ACC  = 4'h2,
		IRQ_PTR  = 4'h4,
		IRQ_CY   = 4'h8
	} cmms_irq_t;
endpackage : cmms_pkg

/* logic/cmms_core.sv */
// Operation
// RQ1: Machine cycle has three states, each one clock period.
// RQ2: Each instruction takes one to five machine cycles.
// RQ3: System clock comes from crystal or RC source, selectable.
// RQ4: Program counter is eleven bits wide.
// RQ5: Program memory holds bytes at 0 to 2047, separate space.
// RQ6: Execution begins at program address zero after reset.
// RQ7: Zero-page call targets entries in 10H to 1FH.
// RQ8: Interrupt vectors come from 020H to 03DH.
// RQ9: Software places no code in 07E0H to 07FFH.
// RQ10: Stack pointer: bits 0 and 7 fixed one, six-bit counter.
// RQ11: Push decrements, pop increments the stack pointer.
// RQ12: Reset loads stack pointer with 0FFH.
// RQ13: Stack pointer accessed only byte-wide.
// RQ14: Writes keep bits 0 and 7; reads return them as one.
// RQ15: Carry flag takes add carry and subtract borrow.
// RQ16: Interrupt entry pushes accumulator pair, primary pointer, carry.
// RQ17: Data memory is four bits wide, separate space.
// RQ18: Data and stack RAM at 780H to 7FFH, stack grows down.
// RQ19: Special registers in bank 0 from 07FH downward.
// RQ20: Data address: three bank bits plus eight offset bits.
// RQ21: Common flag and direct access below 80H selects bank 0.
// RQ22: Bank select LSB zero gives bank 0, one gives bank 7.
// RQ23: Bank source per mode; stack always bank 7.
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module cmms_core
	import cmms_pkg::*;
(
	// System
	input  wire logic        core_clk,
	input  wire logic        nrst,
	// Avalon-MM slave
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Clock source select, from a pin
	input  wire logic        osc_sel_pin,
	// Core status
	output logic [10:0]      prog_addr,
	output logic [10:0]      data_addr,
	output logic [1:0]       mstate,
	output logic             stack_we,
	output logic [7:0]       stack_wdata,
	output logic             clk_src_rc
);
	logic [5:0]  sp_cnt_reg;
	logic [2:0]  bank_select_primary_reg;
	logic [2:0]  bank_select_secondary_reg;
	logic        bank_common_flag_reg;
	logic        bank_enable_flag_reg;
	logic [7:0]  primary_pointer_pair_reg;
	logic [7:0]  secondary_pointer_pair_reg;
	logic [7:0]  acc_pair_reg;
	logic        carry_reg;
	logic [10:0] pc_reg;
	logic [1:0]  state_reg;
	logic [2:0]  mcycle_reg;
	logic [2:0]  instr_len_reg;
	logic        run_reg;
	logic [1:0]  mode_reg;
	logic [7:0]  imm_reg;
	logic [2:0]  vec_idx_reg;
	logic [2:0]  czp_idx_reg;
	logic [3:0]  ctrl_pend_reg;
	logic [2:0]  osc_sync_reg;
	logic        osc_sel_reg;
	logic        resp_reg;
	logic [31:0] rdata_reg;
	cmms_irq_t   irq_state_reg;
	logic [10:0] daddr_next;
	logic [4:0]  sum_next;
	logic        instr_end;
	logic        acc;
	logic        wr_ok;

	function automatic logic [2:0] bank_of(input logic [2:0] sel);
		// RQ22 LSB decode
		return sel[0] ? BANK7 : BANK0;
	endfunction : bank_of

	// RQ10 six-bit counter view
	function automatic logic [7:0] sp_view(input logic [5:0] cnt);
		// RQ14 fixed ones
		return {1'b1, cnt, 1'b1};
	endfunction : sp_view

	assign acc       = (avs_read | avs_write) & ~resp_reg;
	// Writes land on the edge that sees waitrequest low,
	// the same edge at which the master ends the transfer
	assign wr_ok     = avs_write & resp_reg;
	// RQ1 three states
	assign instr_end = run_reg && (state_reg == STATE_LAST) && (mcycle_reg >= instr_len_reg);

	// Bus answers one cycle after the request is seen
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			resp_reg <= 1'b0;
		end else begin
			resp_reg <= acc;
		end
	end
	// Kept combinational: a registered version would cost a cycle per transfer
	assign avs_waitrequest = (avs_read | avs_write) & ~resp_reg;

	// Pin may move at any time; two agreeing stages filter glitches
	// RQ3 source select synchroniser
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			osc_sync_reg <= 3'h0;
			osc_sel_reg  <= 1'b0;
		end else begin
			osc_sync_reg <= {osc_sync_reg[1:0], osc_sel_pin};
			if (osc_sync_reg[2] == osc_sync_reg[1]) begin
				osc_sel_reg <= osc_sync_reg[2];
			end
		end
	end

	// Control register: pending one-shot commands
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			run_reg       <= 1'b0;
			mode_reg      <= 2'h0;
			instr_len_reg <= 3'h0;
			vec_idx_reg   <= 3'h0;
			czp_idx_reg   <= 3'h0;
			ctrl_pend_reg <= 4'h0;
		end else begin
			ctrl_pend_reg <= 4'h0;
			if (wr_ok && avs_address == OFF_CTRL && avs_byteenable[0]) begin
				run_reg       <= avs_writedata[CTRL_RUN];
				ctrl_pend_reg <= {avs_writedata[CTRL_JUMP], avs_writedata[CTRL_CZP],
				                  avs_writedata[CTRL_IRQ], 1'b0};
			end
			if (wr_ok && avs_address == OFF_CTRL && avs_byteenable[1]) begin
				mode_reg    <= avs_writedata[CTRL_MODE_LSB +: 2];
				// RQ2 length 1..5
				if (avs_writedata[CTRL_LEN_LSB +: 3] == 3'h0) begin
					instr_len_reg <= 3'h0;
				end else if (avs_writedata[CTRL_LEN_LSB +: 3] > MCYCLE_LAST + 3'h1) begin
					instr_len_reg <= MCYCLE_LAST;
				end else begin
					instr_len_reg <= avs_writedata[CTRL_LEN_LSB +: 3] - 3'h1;
				end
			end
			if (wr_ok && avs_address == OFF_CTRL && avs_byteenable[2]) begin
				vec_idx_reg <= avs_writedata[CTRL_VEC_LSB +: 3];
				czp_idx_reg <= avs_writedata[CTRL_VEC_LSB + 4 +: 3];
			end
		end
	end

	// Machine state and cycle counters
	// Halted core keeps its place in the cycle
	// Cycle counter wraps at the programmed length
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg  <= 2'h0;
			mcycle_reg <= 3'h0;
		end else if (run_reg) begin
			if (state_reg == STATE_LAST) begin
				state_reg  <= 2'h0;
				mcycle_reg <= instr_end ? 3'h0 : mcycle_reg + 3'h1;
			end else begin
				state_reg <= state_reg + 2'h1;
			end
		end
	end

	// Program counter
	// RQ5 byte addresses 0 to 2047 only
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			// RQ6 start at zero
			pc_reg <= PC_RESET;
		end else if (ctrl_pend_reg[1]) begin
			// RQ8 vector table
			pc_reg <= VEC_LO + {7'h00, vec_idx_reg, 1'b0};
		end else if (ctrl_pend_reg[2]) begin
			// RQ7 zero-page call entries
			pc_reg <= CZP_LO + {7'h00, czp_idx_reg, 1'b0};
		end else if (ctrl_pend_reg[3]) begin
			pc_reg <= rdata_reg[10:0];
		end else if (instr_end) begin
			// RQ4 eleven-bit wrap
			pc_reg <= pc_reg + 11'h001;
		end
	end

	// Stack pointer and interrupt context push
	// Push and pop share the counter; interrupt entry takes precedence
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			// RQ12 reset value
			sp_cnt_reg    <= SP_CNT_RESET;
			irq_state_reg <= IRQ_IDLE;
			stack_we      <= 1'b0;
			stack_wdata   <= 8'h00;
		end else begin
			stack_we <= 1'b0;
			unique case (irq_state_reg)
				IRQ_IDLE: begin
					if (ctrl_pend_reg[1]) begin
						irq_state_reg <= IRQ_ACC;
					// RQ13 byte-wide access only
					end else if (wr_ok && avs_address == OFF_SP && avs_byteenable[0]) begin
						// RQ14 keep fixed bits
						sp_cnt_reg <= avs_writedata[6:1];
					end else if (wr_ok && avs_address == OFF_CTRL && avs_byteenable[0]
					             && avs_writedata[CTRL_PUSH]) begin
						// RQ11 push counts down
						sp_cnt_reg  <= sp_cnt_reg - 6'h01;
						stack_we    <= 1'b1;
						stack_wdata <= acc_pair_reg;
					end else if (wr_ok && avs_address == OFF_CTRL && avs_byteenable[0]
					             && avs_writedata[CTRL_POP]) begin
						// RQ11 pop counts up
						sp_cnt_reg <= sp_cnt_reg + 6'h01;
					end
				end
				// RQ16 context save
				IRQ_ACC: begin
					sp_cnt_reg    <= sp_cnt_reg - 6'h01;
					stack_we      <= 1'b1;
					stack_wdata   <= acc_pair_reg;
					irq_state_reg <= IRQ_PTR;
				end
				IRQ_PTR: begin
					sp_cnt_reg    <= sp_cnt_reg - 6'h01;
					stack_we      <= 1'b1;
					stack_wdata   <= primary_pointer_pair_reg;
					irq_state_reg <= IRQ_CY;
				end
				IRQ_CY: begin
					sp_cnt_reg    <= sp_cnt_reg - 6'h01;
					stack_we      <= 1'b1;
					stack_wdata   <= {7'h00, carry_reg};
					irq_state_reg <= IRQ_IDLE;
				end
				default: begin
					irq_state_reg <= IRQ_IDLE;
				end
			endcase
		end
	end

	// Bank and pointer registers
	// Upper selector bits are stored, but only bit 0 picks the bank
	// Pointers and flags clear with the core
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			bank_select_primary_reg    <= 3'h0;
			bank_select_secondary_reg  <= 3'h0;
			bank_common_flag_reg       <= 1'b0;
			bank_enable_flag_reg       <= 1'b0;
			primary_pointer_pair_reg   <= 8'h00;
			secondary_pointer_pair_reg <= 8'h00;
			imm_reg                    <= 8'h00;
		end else if (wr_ok) begin
			if (avs_address == OFF_BANK && avs_byteenable[0]) begin
				bank_select_primary_reg   <= avs_writedata[2:0];
				bank_select_secondary_reg <= avs_writedata[6:4];
			end
			if (avs_address == OFF_BANK && avs_byteenable[1]) begin
				bank_common_flag_reg <= avs_writedata[8];
				bank_enable_flag_reg <= avs_writedata[9];
			end
			if (avs_address == OFF_PTR && avs_byteenable[0]) begin
				primary_pointer_pair_reg <= avs_writedata[7:0];
			end
			if (avs_address == OFF_PTR && avs_byteenable[1]) begin
				secondary_pointer_pair_reg <= avs_writedata[15:8];
			end
			if (avs_address == OFF_PTR && avs_byteenable[2]) begin
				imm_reg <= avs_writedata[23:16];
			end
		end
	end

	// Accumulator pair and carry
	// Only the low nibble takes part; the high nibble is kept
	assign sum_next = avs_writedata[CTRL_ADD]
	                  ? {1'b0, acc_pair_reg[3:0]} + {1'b0, avs_writedata[27:24]}
	                  : {1'b0, acc_pair_reg[3:0]} - {1'b0, avs_writedata[27:24]};
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			acc_pair_reg <= 8'h00;
			carry_reg    <= 1'b0;
		end else if (wr_ok && avs_address == OFF_ACC && avs_byteenable[0]) begin
			acc_pair_reg <= avs_writedata[7:0];
		end else if (wr_ok && avs_address == OFF_CTRL && avs_byteenable[0] && avs_byteenable[3]
		             && (avs_writedata[CTRL_ADD] | avs_writedata[CTRL_SUB])) begin
			// RQ15 carry or borrow
			acc_pair_reg[3:0] <= sum_next[3:0];
			carry_reg         <= sum_next[4];
		end
	end

	// Data address formation
	// RQ17 nibble space apart from program
	always_comb begin
		daddr_next = {BANK0, imm_reg};
		unique case (mode_reg)
			// RQ23 primary pair bank
			MODE_PRIMARY:   daddr_next = {bank_of(bank_select_primary_reg), primary_pointer_pair_reg};
			MODE_SECONDARY: daddr_next = {bank_of(bank_enable_flag_reg ? bank_select_secondary_reg
			                              : bank_select_primary_reg), secondary_pointer_pair_reg};
			MODE_DIRECT: begin
				// RQ19 special registers below 80H
				// RQ21 common area override
				if (bank_common_flag_reg && imm_reg <= COMMON_HI) begin
					daddr_next = {BANK0, imm_reg};
				end else begin
					// RQ20 bank plus offset
					daddr_next = {bank_of(bank_enable_flag_reg ? bank_select_secondary_reg
					              : bank_select_primary_reg), imm_reg};
				end
			end
			// RQ18 stack in bank 7
			MODE_STACK:     daddr_next = {BANK7, sp_view(sp_cnt_reg)};
		endcase
	end

	// Registered outputs
	// Outputs lag their sources by one clock
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			prog_addr  <= PC_RESET;
			data_addr  <= 11'h000;
			mstate     <= 2'h0;
			clk_src_rc <= 1'b0;
		end else begin
			prog_addr  <= pc_reg;
			data_addr  <= daddr_next;
			mstate     <= state_reg;
			clk_src_rc <= osc_sel_reg;
		end
	end

	// Read data; unmapped offsets read zero
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_reg <= 32'h0000_0000;
		end else if (acc && avs_read) begin
			unique case (avs_address)
				// RQ14 ones read back
				OFF_SP:     rdata_reg <= {24'h00_0000, sp_view(sp_cnt_reg)};
				OFF_BANK:   rdata_reg <= {22'h00_0000, bank_enable_flag_reg, bank_common_flag_reg,
				                          1'b0, bank_select_secondary_reg, 1'b0, bank_select_primary_reg};
				OFF_PTR:    rdata_reg <= {8'h00, imm_reg, secondary_pointer_pair_reg, primary_pointer_pair_reg};
				OFF_CTRL:   rdata_reg <= {13'h0000, vec_idx_reg, 1'b0, instr_len_reg, 2'h0, mode_reg,
				                          7'h00, run_reg};
				OFF_PC:     rdata_reg <= {21'h00_0000, pc_reg};
				OFF_DADDR:  rdata_reg <= {21'h00_0000, daddr_next};
				OFF_STATUS: rdata_reg <= {21'h00_0000, osc_sel_reg, irq_state_reg, carry_reg,
				                          mcycle_reg, state_reg};
				OFF_ACC:    rdata_reg <= {24'h00_0000, acc_pair_reg};
				default:    rdata_reg <= 32'h0000_0000;
			endcase
		// Last PC write is held here for the jump command until the next bus read
		end else if (wr_ok && avs_address == OFF_PC) begin
			rdata_reg <= avs_writedata;
		end
	end
	assign avs_readdata = rdata_reg;
endmodule : cmms_core
`default_nettype wire

/* verif/cmms_core_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module cmms_core_asserts
	import cmms_pkg::*;
(
	// System
	input wire logic        core_clk,
	input wire logic        nrst,
	// Bus
	input wire logic [5:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Status
	input wire logic        osc_sel_pin,
	input wire logic [10:0] prog_addr,
	input wire logic [10:0] data_addr,
	input wire logic [1:0]  mstate,
	input wire logic        clk_src_rc
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	sequence s_req_open;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_rd_done(logic [5:0] a);
		avs_read && !avs_waitrequest && avs_address == a;
	endsequence

	chk_wait_once: assert property (s_req_open |=> !avs_waitrequest)
		else $error("bus answer not after one wait cycle");
	chk_sp_ones: assert property (s_rd_done(OFF_SP) |-> avs_readdata[7] && avs_readdata[0])
		else $error("stack pointer fixed bits not one");
	chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[5] |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	chk_bank_only: assert property (data_addr[10:8] == BANK0 || data_addr[10:8] == BANK7)
		else $error("data bank neither 0 nor 7");
	chk_pc_reset: assert property ($rose(nrst) |-> prog_addr == PC_RESET)
		else $error("program address not zero after reset");
	chk_state_step: assert property ($changed(mstate) |->
		mstate == (($past(mstate) == STATE_LAST) ? 2'h0 : $past(mstate) + 2'h1))
		else $error("machine state skipped");
	chk_state_range: assert property (mstate <= STATE_LAST)
		else $error("machine state beyond third");
	chk_osc_follow: assert property (osc_sel_pin [*6] |-> clk_src_rc)
		else $error("clock source select not followed");
endmodule : cmms_core_asserts
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import cmms_pkg::*;
;
	logic        core_clk       = 1'b0;
	logic        nrst           = 1'b0;
	logic [5:0]  avs_address    = 6'h00;
	logic        avs_read       = 1'b0;
	logic        avs_write      = 1'b0;
	logic [31:0] avs_writedata  = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic        osc_sel_pin    = 1'b0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [10:0] prog_addr;
	logic [10:0] data_addr;
	logic [1:0]  mstate;
	logic        stack_we;
	logic [7:0]  stack_wdata;
	logic        clk_src_rc;
	int          n_fail    = 0;
	int          cmp_count = 0;
	int          cyc       = 0;
	int          pushes    = 0;
	int          p0;
	logic [31:0] rd;
	logic [10:0] exp_a;
	logic [1:0]  m;
	logic        c;
	logic        e;
	logic        s2;
	logic [7:0]  imm;
	// Accumulator, op, operand, nibble, carry
	logic [19:0] alu [4] = '{20'hF1101, 20'h021F1, 20'h22110, 20'h718F0};

	cmms_core i_cmms_core (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .osc_sel_pin(osc_sel_pin),
		.prog_addr(prog_addr), .data_addr(data_addr), .mstate(mstate), .stack_we(stack_we),
		.stack_wdata(stack_wdata), .clk_src_rc(clk_src_rc));

	always #5 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (stack_we === 1'b1)
			pushes <= pushes + 1;
		if (cyc == 5000) begin
			n_fail++;
			report_and_stop();
		end
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// Idle edge after release, so back-to-back calls never drive twice in one step
	task automatic bus_wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask : bus_wr

	task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask : bus_rd

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		bus_rd(OFF_SP, rd);
		check("sp reset", rd[7:0], 8'hFF);
		bus_rd(OFF_PC, rd);
		check("pc reset", rd[10:0], PC_RESET);
		check("prog addr reset", prog_addr, PC_RESET);
		bus_wr(OFF_SP, 32'h0, 4'hF);
		bus_rd(OFF_SP, rd);
		check("sp fixed bits", rd[7:0], 8'h81);
		bus_wr(OFF_SP, 32'h5A, 4'hF);
		// Write without the low byte lane is refused
		bus_wr(OFF_SP, 32'h0, 4'hE);
		bus_rd(OFF_SP, rd);
		check("sp counter", rd[7:0], 8'hDB);
		bus_wr(OFF_CTRL, 32'h2, 4'hF);
		bus_rd(OFF_SP, rd);
		check("sp push", rd[7:0], 8'hD9);
		bus_wr(OFF_CTRL, 32'h4, 4'hF);
		bus_wr(OFF_CTRL, 32'h4, 4'hF);
		bus_rd(OFF_SP, rd);
		check("sp pop", rd[7:0], 8'hDD);
		bus_wr(6'h20, 32'hFFFF_FFFF, 4'hF);
		bus_rd(6'h20, rd);
		check("unmapped", rd, 32'h0);
		bus_wr(OFF_SP, 32'hFF, 4'hF);
		p0 = pushes;
		bus_wr(OFF_CTRL, 32'h0006_0008, 4'hF);
		repeat (8) @(posedge core_clk);
		bus_rd(OFF_SP, rd);
		check("irq sp", rd[7:0], 8'hF9);
		check("irq pushes", 32'(pushes - p0), 32'd3);
		bus_rd(OFF_PC, rd);
		check("vector", rd[10:0], 11'h02C);
		check("prog addr copy", prog_addr, 11'h02C);
		// zero-page call targets stay in 10H to 1FH
		for (int i = 0; i < 8; i++) begin
			bus_wr(OFF_CTRL, 32'h40 | (i << 20), 4'hF);
			bus_rd(OFF_PC, rd);
			check("czp entry", rd[10:0], CZP_LO + 11'(2 * i));
		end
		bus_wr(OFF_PC, 32'hFFFF_FFFF, 4'hF);
		bus_wr(OFF_CTRL, 32'h80, 4'hF);
		bus_rd(OFF_PC, rd);
		check("pc width", rd[15:0], 16'h07FF);
		foreach (alu[k]) begin
			bus_wr(OFF_ACC, {28'h0, alu[k][19:16]}, 4'hF);
			bus_wr(OFF_CTRL, {4'h0, alu[k][11:8], 16'h0, alu[k][15:12], 4'h0}, 4'hF);
			bus_rd(OFF_ACC, rd);
			check("acc nibble", rd[3:0], alu[k][7:4]);
			bus_rd(OFF_STATUS, rd);
			check("carry", rd[5], alu[k][0]);
		end
		for (int n = 0; n < 32; n++) begin
			m = n[1:0];
			c = n[2];
			e = n[3];
			imm = n[4] ? 8'h92 : 8'h12;
			bus_wr(OFF_BANK, {22'h0, e, c, 8'h25}, 4'hF);
			bus_wr(OFF_PTR, {8'h0, imm, 16'hA634}, 4'hF);
			bus_wr(OFF_CTRL, {22'h0, m, 8'h0}, 4'hF);
			bus_rd(OFF_DADDR, rd);
			case (m)
				2'h0: exp_a = {BANK7, 8'h34};
				2'h1: exp_a = {e ? BANK0 : BANK7, 8'hA6};
				2'h2: exp_a = {(e || (c && !imm[7])) ? BANK0 : BANK7, imm};
				default: exp_a = {BANK7, 8'hF9};
			endcase
			check("data addr", rd[10:0], exp_a);
			check("data addr pin", data_addr, exp_a);
		end
		osc_sel_pin <= 1'b1;
		repeat (8) @(posedge core_clk);
		check("clock source", clk_src_rc, 1'b1);
		bus_wr(OFF_CTRL, 32'h5001, 4'hF);
		s2 = 1'b0;
		repeat (30) begin
			@(posedge core_clk);
			if (mstate === STATE_LAST)
				s2 = 1'b1;
		end
		check("third state", s2, 1'b1);
		nrst <= 1'b0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		bus_rd(OFF_SP, rd);
		check("sp second reset", rd[7:0], 8'hFF);
		report_and_stop();
	end
endmodule : tb_top

bind cmms_core cmms_core_asserts i_cmms_core_asserts (.core_clk(core_clk), .nrst(nrst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .osc_sel_pin(osc_sel_pin), .prog_addr(prog_addr),
	.data_addr(data_addr), .mstate(mstate), .clk_src_rc(clk_src_rc));
`default_nettype wire
